// file: hw/smfm_consts.vh
/*
  Constants for the servo motion fault monitor: register offsets, field
  positions, reset values and timing counts.
  Assumes inclusion by bare name from the design file.
*/
`ifndef SMFM_CONSTS_VH
`define SMFM_CONSTS_VH

// Register byte offsets
`define SMFM_OFS_CTRL 8'h00
`define SMFM_OFS_STATUS 8'h04
`define SMFM_OFS_MASK 8'h08
`define SMFM_OFS_FAULT 8'h0c
`define SMFM_OFS_OVSPD 8'h10
`define SMFM_OFS_RATED 8'h14
`define SMFM_OFS_FOLLOW 8'h18
`define SMFM_OFS_LIMLO 8'h1c
`define SMFM_OFS_LIMHI 8'h20
`define SMFM_OFS_OLCUR 8'h24
`define SMFM_OFS_OLTIME 8'h28
`define SMFM_OFS_UNLOCK 8'h2c
`define SMFM_OFS_INDEX 8'h30
`define SMFM_OFS_MAP0 8'h40

// Control fields
`define SMFM_CTRL_SWLIM 0
`define SMFM_CTRL_HWLIM 1
`define SMFM_CTRL_FIXLEN 2
`define SMFM_CTRL_HOMED 3
`define SMFM_CTRL_CLEAR 4

// Status bits, one per fault
`define SMFM_NFAULT 9
`define SMFM_BIT_DUP 0
`define SMFM_BIT_OVSPD 1
`define SMFM_BIT_FOLLOW 2
`define SMFM_BIT_TRIG 3
`define SMFM_BIT_HOME 4
`define SMFM_BIT_OVLD 5
`define SMFM_BIT_SWLIM 6
`define SMFM_BIT_HWLIM 7
`define SMFM_BIT_CURVE 8

// Fault codes
`define SMFM_CODE_DUP 8'hc9
`define SMFM_CODE_OVSPD 8'hca
`define SMFM_CODE_FOLLOW 8'hcb
`define SMFM_CODE_TRIG 8'hcc
`define SMFM_CODE_HOME 8'hcd
`define SMFM_CODE_OVLD 8'hce
`define SMFM_CODE_SWLIM 8'hcf
`define SMFM_CODE_HWLIM 8'hd0
`define SMFM_CODE_CURVE 8'hd1

// Input map and functions
`define SMFM_NTERM 16
`define SMFM_FUNC_NONE 8'h00
`define SMFM_FUNC_FIXLEN 8'h28
`define SMFM_UNLOCK_KEY 16'h20e5

// Reset values
`define SMFM_RST_OVSPD 16'h0078
`define SMFM_RST_RATED 16'h0bb8
`define SMFM_RST_FOLLOW 32'h00010000
`define SMFM_RST_LIMLO 32'h80000000
`define SMFM_RST_LIMHI 32'h7fffffff
`define SMFM_RST_OLCUR 16'h0064
`define SMFM_OLTIME_MS 32'd1000
`define SMFM_CLK_KHZ 32'd50000
`define SMFM_RST_OLTIME (`SMFM_OLTIME_MS * `SMFM_CLK_KHZ)

`endif

// file: hw/smfm_monitor.v
/*
  Servo motion fault monitor: compares speed, position and current with
  thresholds, checks the input-function map, latches coded faults.
  Assumes an Avalon-MM master on core_clk and measured values synchronous
  to core_clk, signed where a direction matters.
*/
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`include "smfm_consts.vh"

// What this block does
// - Flag one input function on two terminals
// - Overspeed when speed percent exceeds threshold
// - Fault when following error exceeds threshold
// - Fixed-length enabled needs a trigger terminal
// - Absolute move before homing raises fault
// - Overload when current stays high too long
// - Software limit: below lower, moving negative
// - Software limit: above upper, moving positive
// - Hardware limit: reverse switch, moving negative
// - Hardware limit: forward switch, moving positive
// - Fault when curve planner fails
module smfm_monitor (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Avalon-MM slave
  input wire [7:0] avmAddress,
  input wire avmRead,
  input wire avmWrite,
  input wire [31:0] avmWriteData,
  input wire [3:0] avmByteEnable,
  output reg [31:0] avmReadData,
  output reg avmWaitRequest,
  // Measurements
  input wire signed [31:0] actualSpeed,
  input wire signed [31:0] commandPosition,
  input wire signed [31:0] actualPosition,
  input wire [15:0] motorCurrent,
  input wire [15:0] ratedCurrent,
  // Switches and events
  input wire forwardLimit,
  input wire reverseLimit,
  input wire absMoveTrigger,
  input wire homingDone,
  input wire planFail,
  // Results
  output reg [7:0] faultCode,
  output reg irq
);

////////////////////////////////////////////////////////////////////////////
reg [4:0] ctrl;
reg [8:0] status;
reg [8:0] mask;
reg [15:0] overspeedPercentThreshold;
reg [15:0] ratedSpeed;
reg [31:0] followingErrorThreshold;
reg signed [31:0] positionLimitLow;
reg signed [31:0] positionLimitHigh;
reg [15:0] overloadCurrentPercent;
reg [31:0] overloadTime;
reg [15:0] offsetUnlock;
reg [31:0] indexPulseOffset;
reg [7:0] inputFunctionNumber [0:`SMFM_NTERM-1];
reg [31:0] overloadCount;
reg homed;
reg ackPend;
reg [8:0] next_event;
reg dupHit;
reg trigHit;
integer i;
integer j;
integer r;
reg [31:0] regWord;

// Merge a write into a word under byte enables
function [31:0] mergeBytes;
  input [31:0] old;
  input [31:0] data;
  input [3:0] be;
  integer k;
  begin
    mergeBytes = old;
    for (k = 0; k < 4; k = k + 1) begin
      if (be[k])
        mergeBytes[k*8 +: 8] = data[k*8 +: 8];
    end
  end
endfunction

// Lowest set status bit selects the visible code
function [7:0] codeOf;
  input [8:0] s;
  begin
    codeOf = 8'h00;
    if (s[`SMFM_BIT_DUP]) codeOf = `SMFM_CODE_DUP;
    else if (s[`SMFM_BIT_OVSPD]) codeOf = `SMFM_CODE_OVSPD;
    else if (s[`SMFM_BIT_FOLLOW]) codeOf = `SMFM_CODE_FOLLOW;
    else if (s[`SMFM_BIT_TRIG]) codeOf = `SMFM_CODE_TRIG;
    else if (s[`SMFM_BIT_HOME]) codeOf = `SMFM_CODE_HOME;
    else if (s[`SMFM_BIT_OVLD]) codeOf = `SMFM_CODE_OVLD;
    else if (s[`SMFM_BIT_SWLIM]) codeOf = `SMFM_CODE_SWLIM;
    else if (s[`SMFM_BIT_HWLIM]) codeOf = `SMFM_CODE_HWLIM;
    else if (s[`SMFM_BIT_CURVE]) codeOf = `SMFM_CODE_CURVE;
  end
endfunction

// Input-map window: one word per terminal, low byte used
function isMap;
  input [7:0] a;
  begin
    isMap = a >= `SMFM_OFS_MAP0 && a < `SMFM_OFS_MAP0 + 8'h40;
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// Fault detection
wire [31:0] speedMag = actualSpeed[31] ? -actualSpeed : actualSpeed;
wire signed [32:0] posDiff = {commandPosition[31], commandPosition} -
  {actualPosition[31], actualPosition};
wire [32:0] posErr = posDiff[32] ? -posDiff : posDiff;
// Products avoid a divider; 48 bits hold both sides without overflow
wire [47:0] speedLhs = {16'h0000, speedMag} * 48'd100;
wire [47:0] speedRhs = {32'h00000000, ratedSpeed} *
  {32'h00000000, overspeedPercentThreshold};
wire [31:0] curLhs = {16'h0000, motorCurrent} * 32'd100;
wire [31:0] curRhs = {16'h0000, ratedCurrent} *
  {16'h0000, overloadCurrentPercent};
wire overCurrent = curLhs > curRhs;

always @* begin
  dupHit = 1'b0;
  trigHit = 1'b0;
  for (i = 0; i < `SMFM_NTERM; i = i + 1) begin
    if (inputFunctionNumber[i] == `SMFM_FUNC_FIXLEN)
      trigHit = 1'b1;
    for (j = i + 1; j < `SMFM_NTERM; j = j + 1) begin
      if (inputFunctionNumber[i] != `SMFM_FUNC_NONE &&
          inputFunctionNumber[i] == inputFunctionNumber[j])
        dupHit = 1'b1;
    end
  end
  next_event = 9'h000;
  next_event[`SMFM_BIT_DUP] = dupHit;
  next_event[`SMFM_BIT_OVSPD] = speedLhs > speedRhs;
  next_event[`SMFM_BIT_FOLLOW] =
    posErr > {1'b0, followingErrorThreshold};
  next_event[`SMFM_BIT_TRIG] = ctrl[`SMFM_CTRL_FIXLEN] & ~trigHit;
  next_event[`SMFM_BIT_HOME] = absMoveTrigger & ~homed;
  next_event[`SMFM_BIT_OVLD] = overCurrent &&
    overloadCount >= overloadTime;
  next_event[`SMFM_BIT_SWLIM] = ctrl[`SMFM_CTRL_SWLIM] &&
    ((actualPosition < positionLimitLow && actualSpeed < 0) ||
     (actualPosition > positionLimitHigh && actualSpeed > 0));
  next_event[`SMFM_BIT_HWLIM] = ctrl[`SMFM_CTRL_HWLIM] &&
    ((reverseLimit && actualSpeed < 0) ||
     (forwardLimit && actualSpeed > 0));
  next_event[`SMFM_BIT_CURVE] = planFail;
end

// Time over the overload current threshold; any dip restarts the count
always @(posedge core_clk) begin
  if (!resetn)
    overloadCount <= 32'h00000000;
  else if (!overCurrent)
    overloadCount <= 32'h00000000;
  else if (overloadCount < overloadTime)
    overloadCount <= overloadCount + 32'h00000001;
end

// Homing memory
always @(posedge core_clk) begin
  if (!resetn)
    homed <= 1'b0;
  else if (homingDone)
    homed <= 1'b1;
end

////////////////////////////////////////////////////////////////////////////
// Register bus: one wait cycle, then the answer
wire avmHit = (avmRead | avmWrite) & ~ackPend;
wire wrNow = avmWrite & ackPend;
wire clearReq = wrNow && avmAddress == `SMFM_OFS_CTRL &&
  avmByteEnable[0] && avmWriteData[`SMFM_CTRL_CLEAR];
// Write one to clear; bit 8 rides in the second byte lane
wire [8:0] w1c = (wrNow && avmAddress == `SMFM_OFS_STATUS) ?
  {avmByteEnable[1] & avmWriteData[8],
   avmWriteData[7:0] & {8{avmByteEnable[0]}}} : 9'h000;
wire [31:0] mergedWord = mergeBytes(regWord, avmWriteData, avmByteEnable);

// Addressed register as software sees it; the read path and the write
// merge share this decode, so a partial write keeps the other lanes
always @* begin
  regWord = 32'h00000000;
  if (isMap(avmAddress))
    regWord = {24'h000000, inputFunctionNumber[avmAddress[5:2]]};
  else begin
    case (avmAddress)
      `SMFM_OFS_CTRL: regWord = {27'h0, ctrl};
      `SMFM_OFS_STATUS: regWord = {23'h0, status};
      `SMFM_OFS_MASK: regWord = {23'h0, mask};
      `SMFM_OFS_FAULT: regWord = {24'h0, faultCode};
      `SMFM_OFS_OVSPD: regWord = {16'h0, overspeedPercentThreshold};
      `SMFM_OFS_RATED: regWord = {16'h0, ratedSpeed};
      `SMFM_OFS_FOLLOW: regWord = followingErrorThreshold;
      `SMFM_OFS_LIMLO: regWord = positionLimitLow;
      `SMFM_OFS_LIMHI: regWord = positionLimitHigh;
      `SMFM_OFS_OLCUR: regWord = {16'h0, overloadCurrentPercent};
      `SMFM_OFS_OLTIME: regWord = overloadTime;
      `SMFM_OFS_UNLOCK: regWord = {16'h0, offsetUnlock};
      `SMFM_OFS_INDEX: regWord = indexPulseOffset;
      default: regWord = 32'h00000000;
    endcase
  end
end

always @(posedge core_clk) begin
  if (!resetn) begin
    ackPend <= 1'b0;
    avmWaitRequest <= 1'b1;
    avmReadData <= 32'h00000000;
  end else begin
    ackPend <= avmHit;
    avmWaitRequest <= ~avmHit;
    avmReadData <= 32'h00000000;
    if (avmHit && avmRead)
      avmReadData <= regWord;
  end
end

always @(posedge core_clk) begin
  if (!resetn) begin
    ctrl <= 5'h00;
    mask <= 9'h000;
    overspeedPercentThreshold <= `SMFM_RST_OVSPD;
    ratedSpeed <= `SMFM_RST_RATED;
    followingErrorThreshold <= `SMFM_RST_FOLLOW;
    positionLimitLow <= `SMFM_RST_LIMLO;
    positionLimitHigh <= `SMFM_RST_LIMHI;
    overloadCurrentPercent <= `SMFM_RST_OLCUR;
    overloadTime <= `SMFM_RST_OLTIME;
    offsetUnlock <= 16'h0000;
    indexPulseOffset <= 32'h00000000;
    for (r = 0; r < `SMFM_NTERM; r = r + 1)
      inputFunctionNumber[r] <= `SMFM_FUNC_NONE;
  end else begin
    ctrl[`SMFM_CTRL_CLEAR] <= 1'b0;
    if (wrNow) begin
      if (isMap(avmAddress)) begin
        if (avmByteEnable[0])
          inputFunctionNumber[avmAddress[5:2]] <= avmWriteData[7:0];
      end else begin
        case (avmAddress)
          `SMFM_OFS_CTRL:
            if (avmByteEnable[0])
              ctrl[3:0] <= avmWriteData[3:0];
          `SMFM_OFS_MASK:
            mask <= mergedWord[8:0];
          `SMFM_OFS_OVSPD:
            overspeedPercentThreshold <= mergedWord[15:0];
          `SMFM_OFS_RATED:
            ratedSpeed <= mergedWord[15:0];
          `SMFM_OFS_FOLLOW:
            followingErrorThreshold <= mergedWord;
          `SMFM_OFS_LIMLO:
            positionLimitLow <= mergedWord;
          `SMFM_OFS_LIMHI:
            positionLimitHigh <= mergedWord;
          `SMFM_OFS_OLCUR:
            overloadCurrentPercent <= mergedWord[15:0];
          `SMFM_OFS_OLTIME:
            overloadTime <= mergedWord;
          `SMFM_OFS_UNLOCK:
            offsetUnlock <= mergedWord[15:0];
          `SMFM_OFS_INDEX:
            // Guarded so a stray write cannot shift commutation
            if (offsetUnlock == `SMFM_UNLOCK_KEY)
              indexPulseOffset <= mergedWord;
          default: ;
        endcase
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Fault latch: a new event wins over clear in the same cycle
always @(posedge core_clk) begin
  if (!resetn) begin
    status <= 9'h000;
    faultCode <= 8'h00;
    irq <= 1'b0;
  end else begin
    status <= ((clearReq ? 9'h000 : status) & ~w1c) | next_event;
    faultCode <= codeOf(((clearReq ? 9'h000 : status) & ~w1c) |
      next_event);
    irq <= |((((clearReq ? 9'h000 : status) & ~w1c) | next_event) & mask);
  end
end

endmodule // smfm_monitor

// file: dv/smfm_monitor_chk.sv
/*
  Checker for the fault monitor: bus answer timing and fault outputs.
  Assumes it sees only the monitor's ports; bound after the module.
*/
`timescale 1ns/100ps
module smfm_monitor_chk (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Bus
  input wire avmRead,
  input wire avmWrite,
  input wire [31:0] avmReadData,
  input wire avmWaitRequest,
  // Faults
  input wire planFail,
  input wire [7:0] faultCode,
  input wire irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  a_wait_answers: assert property ((avmRead || avmWrite) && avmWaitRequest
    |=> !avmWaitRequest) else $error("request not answered");
  a_wait_low_once: assert property (!avmWaitRequest |=> avmWaitRequest)
    else $error("waitrequest low too long");
  a_wait_idle: assert property (!(avmRead || avmWrite) |=> avmWaitRequest)
    else $error("answer without request");
  a_read_zero_idle: assert property (avmWaitRequest |-> avmReadData == 0)
    else $error("read data outside answer");
  a_code_in_range: assert property (faultCode != 8'h00 |->
    faultCode >= 8'hc9 && faultCode <= 8'hd1) else $error("bad fault code");
  a_irq_needs_fault: assert property (faultCode == 8'h00 |-> !irq)
    else $error("irq without fault");
  a_plan_latch: assert property (planFail |=> faultCode != 8'h00)
    else $error("planner failure not reported");
  a_fault_holds: assert property (faultCode != 8'h00 && !avmWrite &&
    !$past(avmWrite) |=> faultCode != 8'h00) else $error("fault lost");
endmodule // smfm_monitor_chk

bind smfm_monitor smfm_monitor_chk u_chk (.core_clk(core_clk),
  .resetn(resetn), .avmRead(avmRead), .avmWrite(avmWrite),
  .avmReadData(avmReadData), .avmWaitRequest(avmWaitRequest),
  .planFail(planFail), .faultCode(faultCode), .irq(irq));

// file: dv/smfm_monitor_bench.sv
/*
  Self-checking bench for the fault monitor, driven over Avalon-MM.
  Assumes the checker file is compiled alongside and binds itself.
*/
`timescale 1ns/100ps
`include "smfm_consts.vh"
module smfm_monitor_bench;
  logic core_clk = 0, resetn = 0, avmRead = 0, avmWrite = 0;
  logic [7:0] avmAddress = 0;
  logic [31:0] avmWriteData = 0, rdv;
  logic [3:0] avmByteEnable = 4'hf;
  logic signed [31:0] actualSpeed = 0, commandPosition = 0;
  logic signed [31:0] actualPosition = 0;
  logic [15:0] motorCurrent = 0, ratedCurrent = 16'h0064;
  logic forwardLimit = 0, reverseLimit = 0, absMoveTrigger = 0;
  logic homingDone = 0, planFail = 0;
  logic [8:0] msk;
  wire [31:0] avmReadData;
  wire [7:0] faultCode;
  wire avmWaitRequest, irq;
  int n_mismatch = 0, num_checks = 0;
  smfm_monitor u_dut (.core_clk, .resetn, .avmAddress, .avmRead,
    .avmWrite, .avmWriteData, .avmByteEnable, .avmReadData, .avmWaitRequest,
    .actualSpeed, .commandPosition, .actualPosition, .motorCurrent,
    .ratedCurrent, .forwardLimit, .reverseLimit, .absMoveTrigger,
    .homingDone, .planFail, .faultCode, .irq);
  initial forever #10 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Entered just after a rising edge; waitrequest and read data are taken
  // at the rising edge, then one idle edge passes so the next request
  // never reassigns a strobe in the same time step
  task bus(input w, input [7:0] a, input [31:0] d);
    int n;
    n = 0;
    avmAddress <= a;
    avmWriteData <= d;
    avmWrite <= w;
    avmRead <= !w;
    @(posedge core_clk);
    while (avmWaitRequest !== 1'b0 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    chk(n < 20, 1, "answer");
    rdv = avmReadData;
    avmRead <= 1'b0;
    avmWrite <= 1'b0;
    @(posedge core_clk);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdv, e, $sformatf("reg %h", a));
  endtask
  task look(input [8:0] e);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 8; i >= 0; i--) if (e[i]) c = 8'hc9 + 8'(i);
    rd(`SMFM_OFS_STATUS, {23'h0, e});
    rd(`SMFM_OFS_FAULT, {24'h0, c});
    @(negedge core_clk);
    chk(faultCode, c, "faultCode");
    chk(irq, |(e & msk), "irq");
    @(posedge core_clk);
  endtask
  // Apply a condition, remove it, then expect the latched bits
  task probe(input [31:0] spd, pos, cmd, input [3:0] sw,
             input [15:0] cur, input int hold, input [8:0] e);
    actualSpeed <= spd;
    actualPosition <= pos;
    commandPosition <= cmd;
    {forwardLimit, reverseLimit, absMoveTrigger, planFail} <= sw;
    motorCurrent <= cur;
    repeat (hold) @(posedge core_clk);
    actualSpeed <= 32'h0;
    actualPosition <= 32'h0;
    commandPosition <= 32'h0;
    {forwardLimit, reverseLimit, absMoveTrigger, planFail} <= 4'h0;
    motorCurrent <= 16'h0;
    @(posedge core_clk);
    look(e);
    wr(`SMFM_OFS_STATUS, 32'h1ff);
    rd(`SMFM_OFS_STATUS, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    msk = 9'h1ff;
    look(9'h000);
    rd(`SMFM_OFS_OVSPD, `SMFM_RST_OVSPD);
    rd(`SMFM_OFS_CTRL, 32'h0);
    rd(8'h80, 32'h0);
    wr(`SMFM_OFS_MASK, 32'h1ff);
    wr(`SMFM_OFS_OLTIME, 32'h0a);
    wr(`SMFM_OFS_LIMLO, 32'hffffff9c);
    wr(`SMFM_OFS_LIMHI, 32'h64);
    probe(32'he10, 0, 0, 4'h0, 0, 3, 9'h000);
    probe(32'he11, 0, 0, 4'h0, 0, 3, 9'h002);
    probe(32'hfffff1ef, 0, 0, 4'h0, 0, 3, 9'h002);
    probe(0, 0, 32'h10000, 4'h0, 0, 3, 9'h000);
    probe(0, 0, 32'h10001, 4'h0, 0, 3, 9'h004);
    probe(0, 32'h10001, 0, 4'h0, 0, 3, 9'h004);
    probe(0, 0, 0, 4'h0, 16'h65, 8, 9'h000);
    probe(0, 0, 0, 4'h0, 16'h64, 30, 9'h000);
    probe(0, 0, 0, 4'h0, 16'h65, 30, 9'h020);
    probe(0, 0, 0, 4'h1, 0, 1, 9'h100);
    probe(0, 0, 0, 4'h2, 0, 3, 9'h010);
    wr(`SMFM_OFS_CTRL, 32'h1);
    probe(32'hffffffff, 32'hffffff9b, 32'hffffff9b, 0, 0, 3, 9'h040);
    probe(32'h1, 32'hffffff9b, 32'hffffff9b, 0, 0, 3, 9'h000);
    probe(32'h1, 32'h65, 32'h65, 4'h0, 0, 3, 9'h040);
    probe(32'hffffffff, 32'h65, 32'h65, 4'h0, 0, 3, 9'h000);
    probe(32'h1, 0, 0, 4'h8, 0, 3, 9'h000);
    wr(`SMFM_OFS_CTRL, 32'h2);
    probe(32'hffffffff, 0, 0, 4'h4, 0, 3, 9'h080);
    probe(32'h1, 0, 0, 4'h4, 0, 3, 9'h000);
    probe(32'h1, 0, 0, 4'h8, 0, 3, 9'h080);
    probe(32'hffffffff, 0, 0, 4'h8, 0, 3, 9'h000);
    // Homing is remembered, so this follows the not-homed case
    homingDone <= 1'b1;
    @(posedge core_clk);
    homingDone <= 1'b0;
    @(posedge core_clk);
    probe(0, 0, 0, 4'h2, 0, 3, 9'h000);
    msk = 9'h000;
    wr(`SMFM_OFS_MASK, 32'h0);
    planFail <= 1'b1;
    @(posedge core_clk);
    planFail <= 1'b0;
    @(posedge core_clk);
    look(9'h100);
    msk = 9'h100;
    wr(`SMFM_OFS_MASK, 32'h100);
    look(9'h100);
    // An event at the clearing edge wins over the clear
    planFail <= 1'b1;
    wr(`SMFM_OFS_CTRL, 32'h10);
    planFail <= 1'b0;
    look(9'h100);
    wr(`SMFM_OFS_CTRL, 32'h10);
    look(9'h000);
    rd(`SMFM_OFS_CTRL, 32'h0);
    msk = 9'h1ff;
    wr(`SMFM_OFS_MASK, 32'h1ff);
    wr(`SMFM_OFS_MAP0, 32'h05);
    wr(`SMFM_OFS_MAP0 + 8'h04, 32'h05);
    look(9'h001);
    wr(`SMFM_OFS_MAP0 + 8'h04, 32'h0);
    wr(`SMFM_OFS_STATUS, 32'h1ff);
    look(9'h000);
    wr(`SMFM_OFS_CTRL, 32'h4);
    look(9'h008);
    wr(`SMFM_OFS_MAP0 + 8'h08, 32'h28);
    wr(`SMFM_OFS_STATUS, 32'h1ff);
    look(9'h000);
    wr(`SMFM_OFS_INDEX, 32'h5);
    rd(`SMFM_OFS_INDEX, 32'h0);
    wr(`SMFM_OFS_UNLOCK, 32'h20e5);
    wr(`SMFM_OFS_INDEX, 32'h5);
    rd(`SMFM_OFS_INDEX, 32'h5);
    // Byte lanes: only the enabled lanes of a write land
    avmByteEnable <= 4'h1;
    wr(`SMFM_OFS_FOLLOW, 32'h11223344);
    avmByteEnable <= 4'hf;
    rd(`SMFM_OFS_FOLLOW, 32'h00010044);
    planFail <= 1'b1;
    @(posedge core_clk);
    planFail <= 1'b0;
    avmByteEnable <= 4'h1;
    wr(`SMFM_OFS_STATUS, 32'h1ff);
    avmByteEnable <= 4'hf;
    look(9'h100);
    wrap_up;
  end
endmodule // smfm_monitor_bench
